// ### logic/ssd_pkg.sv
// Package for the safety sensor diagnostics: status bit positions, cause codes,
// timing counts and the states of the sensor and the chain gateway.
// Assumes a 50 MHz clock shared by the sensor end and the gateway end.
package ssd_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned WARN_MINUTES    = 30;
   // The warning delay needs a 37-bit counter, so the count is kept as a longint.
   localparam longint unsigned WARN_CYCLES = longint'(WARN_MINUTES) * 60 * CLK_HZ;
   localparam int unsigned FLASH_HZ        = 1;
   localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (2 * FLASH_HZ);
   localparam int unsigned PULSE_HALF_CYC  = FLASH_HALF_CYC;

   // ---------------------------------------------------------------
   // Chain size
   // ---------------------------------------------------------------
   localparam int unsigned MAX_SENSORS     = 31;
   localparam int unsigned IDX_W           = 5;

   // ---------------------------------------------------------------
   // Response byte bit positions
   // ---------------------------------------------------------------
   localparam int unsigned RSP_OUT_EN      = 0;
   localparam int unsigned RSP_ACTUATED    = 1;
   localparam int unsigned RSP_INPUTS_LIVE = 4;
   localparam int unsigned RSP_HYST        = 5;
   localparam int unsigned RSP_WARNING     = 6;
   localparam int unsigned RSP_ERROR       = 7;

   // ---------------------------------------------------------------
   // Request byte and cause byte bit positions
   // ---------------------------------------------------------------
   localparam int unsigned REQ_RESET       = 7;
   localparam int unsigned CAUSE_OUT_ONE   = 0;
   localparam int unsigned CAUSE_OUT_TWO   = 1;
   localparam int unsigned CAUSE_CROSS     = 2;
   localparam int unsigned CAUSE_TEMP      = 3;
   localparam int unsigned CAUSE_ACTUATOR  = 4;
   localparam int unsigned CAUSE_INTERNAL  = 5;
   localparam int unsigned CAUSE_COMM      = 6;
   localparam logic [7:0]  CAUSE_WARN_MASK = 8'h6F;
   localparam logic [7:0]  CAUSE_ERR_MASK  = 8'h3F;
   localparam logic [7:0]  CAUSE_OUT_MASK  = 8'h03;
   localparam logic [7:0]  BYTE_RESET      = 8'h00;

   // ---------------------------------------------------------------
   // Link frame: a request byte goes out, three bytes come back
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS      = 8;
   localparam int unsigned REPLY_BITS      = 24;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {SSD_IDLE, SSD_ON, SSD_HYST, SSD_WARN, SSD_ERROR} ssd_mode_e;
   typedef enum logic [1:0] {SSD_G_IDLE, SSD_G_SEND, SSD_G_RECV, SSD_G_STORE} ssd_gw_e;

endpackage : ssd_pkg

// ### logic/ssd_link_if.sv
// Interface joining one sensor's serial diagnostic pair to the chain gateway.
// Assumes both ends share clock; each direction of the link is one strobe with one data bit, and the gateway also drives sensor_idx.
`timescale 1ns/1ps
interface ssd_link_if;
   logic       req_valid;
   logic       req_bit;
   logic       rsp_valid;
   logic       rsp_bit;
   logic [4:0] sensor_idx;

   modport gateway (output req_valid, output req_bit, output sensor_idx,
                    input rsp_valid, input rsp_bit);
   modport sensor  (input req_valid, input req_bit, input sensor_idx,
                    output rsp_valid, output rsp_bit);
endinterface : ssd_link_if

// ### logic/ssd_sensor.sv
// Sensor end: safety outputs, indicators, diagnostic output, status bytes and
// the serial diagnostic reply shifter.
// Assumes sensing inputs other than link_error and my_index arrive from pins and pass two flip-flops first.
`timescale 1ns/1ps
module ssd_sensor
   import ssd_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                reset_n,
   // Sensing pins
   input  wire logic                actuator_in,
   input  wire logic                hyst_in,
   input  wire logic                safety_input_one,
   input  wire logic                safety_input_two,
   input  wire logic [7:0]          fault_in,
   input  wire logic                link_error,
   input  wire logic [4:0]          my_index,
   // Serial diagnostic pair
   ssd_link_if.sensor               serial_diagnostic,
   // Safety and indicator outputs
   output logic                     safety_output_one,
   output logic                     safety_output_two,
   output logic                     diag_out,
   output logic                     led_green,
   output logic                     led_yellow,
   output logic                     led_red
);
   import ssd_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [11:0] sync1;
      logic [11:0] sync2;
      ssd_mode_e   mode;
      logic [7:0]  err_cause;
      logic [7:0]  warn_cause;
      logic        req_bit7;
      logic [7:0]  req_shift;
      logic [3:0]  req_cnt;
      logic [23:0] rsp_shift;
      logic [4:0]  rsp_cnt;
      logic        rsp_valid;
      logic        rsp_bit;
      logic [36:0] warn_cnt;
      logic [24:0] flash_cnt;
      logic        flash;
      logic        out_en;
      logic        diag;
      logic        g;
      logic        y;
      logic        r;
   } ssd_sns_s;

   ssd_sns_s s_r, s_nxt;

   logic        act, hyst, in1, in2, lerr, live, reset_edge, opened;
   logic [7:0]  flt, rsp_byte, cause_byte;
   logic        hit;

   assign act  = s_r.sync2[0];
   assign hyst = s_r.sync2[1];
   assign in1  = s_r.sync2[2];
   assign in2  = s_r.sync2[3];
   assign flt  = s_r.sync2[11:4];
   assign live = in1 & in2;
   assign lerr = link_error;
   assign hit  = serial_diagnostic.sensor_idx == my_index;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt       = s_r;
      reset_edge  = 1'b0;
      opened      = 1'b0;
      s_nxt.sync1 = {fault_in, safety_input_two, safety_input_one, hyst_in, actuator_in};
      s_nxt.sync2 = s_r.sync1;

      // Blink base: one half period per toggle gives 1 Hz.
      if (s_r.flash_cnt == 25'(FLASH_HALF_CYC - 1)) begin
         s_nxt.flash_cnt = '0;
         s_nxt.flash     = ~s_r.flash;
      end else begin
         s_nxt.flash_cnt = s_r.flash_cnt + 25'd1;
      end

      // Request byte receive; bit 7 falling edge requests an error reset.
      if (serial_diagnostic.req_valid && hit) begin
         s_nxt.req_shift = {s_r.req_shift[6:0], serial_diagnostic.req_bit};
         if (s_r.req_cnt == 4'(FRAME_BITS - 1)) begin
            s_nxt.req_cnt  = '0;
            s_nxt.req_bit7 = s_r.req_shift[6];
            reset_edge     = s_r.req_bit7 & ~s_r.req_shift[6];
         end else begin
            s_nxt.req_cnt = s_r.req_cnt + 4'd1;
         end
      end

      // Warnings follow their cause directly and clear by themselves.
      s_nxt.warn_cause = flt & CAUSE_WARN_MASK;
      s_nxt.warn_cause[CAUSE_COMM] = lerr;

      // Error causes latch; output faults clear only on a reset request with the actuator closed.
      opened = ~act;
      for (int i = 0; i < 8; i++) begin
         if (CAUSE_ERR_MASK[i] && s_r.mode == SSD_ERROR && flt[i]) begin
            s_nxt.err_cause[i] = 1'b1;
         end else if (!flt[i] && (reset_edge || opened) && !CAUSE_OUT_MASK[i]) begin
            s_nxt.err_cause[i] = 1'b0;
         end else if (CAUSE_OUT_MASK[i] && s_r.out_en == 1'b0 && act && !flt[i]
                      && (reset_edge || opened)) begin
            s_nxt.err_cause[i] = 1'b0;
         end
      end

      // Warning timer: thirty minutes of warning escalates to error.
      if (s_r.mode == SSD_WARN) begin
         s_nxt.warn_cnt = s_r.warn_cnt + 37'd1;
      end else begin
         s_nxt.warn_cnt = '0;
      end

      case (s_r.mode)
         SSD_ERROR: begin
            if (s_nxt.err_cause == BYTE_RESET && !(flt[CAUSE_INTERNAL]
                || flt[CAUSE_ACTUATOR])) begin
               s_nxt.mode = act ? SSD_ON : SSD_IDLE;
            end
         end
         default: begin
            if (flt[CAUSE_INTERNAL] || flt[CAUSE_ACTUATOR]) begin
               s_nxt.mode      = SSD_ERROR;
               s_nxt.err_cause = flt & CAUSE_ERR_MASK;
            end else if (s_r.mode == SSD_WARN && s_r.warn_cnt == 37'(WARN_CYCLES - 1)) begin
               s_nxt.mode      = SSD_ERROR;
               s_nxt.err_cause = flt & CAUSE_ERR_MASK;
            end else if (lerr) begin
               // A link fault freezes the mode; only a device fault or the warning timeout still shuts down.
               s_nxt.mode = s_r.mode;
            end else if (!act || !live) begin
               s_nxt.mode = SSD_IDLE;
            end else if ((flt & CAUSE_WARN_MASK) != BYTE_RESET) begin
               s_nxt.mode = SSD_WARN;
            end else if (hyst) begin
               s_nxt.mode = SSD_HYST;
            end else begin
               s_nxt.mode = SSD_ON;
            end
         end
      endcase

      // Outputs follow the mode.
      s_nxt.out_en = 1'b0;
      s_nxt.diag   = 1'b0;
      s_nxt.g      = 1'b0;
      s_nxt.y      = 1'b0;
      s_nxt.r      = 1'b0;
      case (s_nxt.mode)
         SSD_IDLE: s_nxt.g = 1'b1;
         SSD_ON: begin
            s_nxt.out_en = 1'b1;
            s_nxt.diag   = 1'b1;
            s_nxt.y      = 1'b1;
         end
         SSD_HYST: begin
            s_nxt.out_en = 1'b1;
            s_nxt.diag   = s_r.flash;
            s_nxt.y      = s_r.flash;
         end
         SSD_WARN: begin
            s_nxt.out_en = 1'b1;
            s_nxt.r      = s_r.flash;
         end
         SSD_ERROR: s_nxt.r = s_r.flash;
         default: s_nxt.g = 1'b1;
      endcase

      // Reply: response, warning cause, error cause, shifted MSB first.
      rsp_byte = BYTE_RESET;
      rsp_byte[RSP_OUT_EN]      = s_r.out_en;
      rsp_byte[RSP_ACTUATED]    = act;
      rsp_byte[RSP_INPUTS_LIVE] = live;
      rsp_byte[RSP_HYST]        = s_r.mode == SSD_HYST;
      rsp_byte[RSP_WARNING]     = s_r.mode == SSD_WARN || s_r.mode == SSD_ERROR;
      rsp_byte[RSP_ERROR]       = s_r.mode == SSD_ERROR;
      cause_byte = s_r.mode == SSD_ERROR ? s_r.err_cause : BYTE_RESET;
      s_nxt.rsp_valid = 1'b0;
      if (serial_diagnostic.req_valid && hit && s_r.req_cnt == 4'(FRAME_BITS - 1)) begin
         s_nxt.rsp_shift = {rsp_byte, s_r.warn_cause, cause_byte};
         s_nxt.rsp_cnt   = 5'(REPLY_BITS);
      end else if (s_r.rsp_cnt != '0) begin
         s_nxt.rsp_valid = 1'b1;
         s_nxt.rsp_bit   = s_r.rsp_shift[23];
         s_nxt.rsp_shift = {s_r.rsp_shift[22:0], 1'b0};
         s_nxt.rsp_cnt   = s_r.rsp_cnt - 5'd1;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_r      <= '0;
         s_r.mode <= SSD_IDLE;
         s_r.g    <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign safety_output_one           = s_r.out_en;
   assign safety_output_two           = s_r.out_en;
   assign diag_out                    = s_r.diag;
   assign led_green                   = s_r.g;
   assign led_yellow                  = s_r.y;
   assign led_red                     = s_r.r;
   assign serial_diagnostic.rsp_valid = s_r.rsp_valid;
   assign serial_diagnostic.rsp_bit   = s_r.rsp_bit;

endmodule : ssd_sensor

// ### logic/ssd_gateway.sv
// Gateway end: polls each sensor of the chain in turn, sends its request byte
// and stores the returned response, warning and error bytes.
// Assumes software reads the stored bytes over a plain port, data one cycle later.
`timescale 1ns/1ps
module ssd_gateway
   import ssd_pkg::*;
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                reset_n,
   // Software port
   input  wire logic [7:0]          addr,
   input  wire logic [7:0]          wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic [7:0]               rdata,
   // Chain setup
   input  wire logic [4:0]          chain_len,
   // Serial diagnostic link
   ssd_link_if.gateway              serial_diagnostic
);
   import ssd_pkg::*;

   // Address: bits 7:6 pick request(0), response(1), warning(2), error(3).
   logic [7:0] req_mem  [MAX_SENSORS];
   logic [7:0] rsp_mem  [MAX_SENSORS];
   logic [7:0] warn_mem [MAX_SENSORS];
   logic [7:0] err_mem  [MAX_SENSORS];

   typedef struct packed {
      ssd_gw_e     st;
      logic [4:0]  idx;
      logic [4:0]  cnt;
      logic [7:0]  tx;
      logic [23:0] rx;
      logic        v;
      logic        b;
      logic [7:0]  rdata;
   } ssd_gw_s;

   ssd_gw_s g_r, g_nxt;
   logic [4:0] last, sel;

   // Chain length is clipped so no more than 31 sensors are polled.
   assign last = (chain_len == '0) ? 5'(MAX_SENSORS - 1) : chain_len - 5'd1;
   assign sel  = addr[4:0];

   always_comb begin
      g_nxt   = g_r;
      g_nxt.v = 1'b0;
      case (g_r.st)
         SSD_G_IDLE: begin
            g_nxt.tx  = req_mem[g_r.idx];
            g_nxt.cnt = 5'(FRAME_BITS);
            g_nxt.st  = SSD_G_SEND;
         end
         SSD_G_SEND: begin
            g_nxt.v   = 1'b1;
            g_nxt.b   = g_r.tx[7];
            g_nxt.tx  = {g_r.tx[6:0], 1'b0};
            g_nxt.cnt = g_r.cnt - 5'd1;
            if (g_r.cnt == 5'd1) begin
               g_nxt.cnt = 5'(REPLY_BITS);
               g_nxt.st  = SSD_G_RECV;
            end
         end
         SSD_G_RECV: begin
            if (serial_diagnostic.rsp_valid) begin
               g_nxt.rx  = {g_r.rx[22:0], serial_diagnostic.rsp_bit};
               g_nxt.cnt = g_r.cnt - 5'd1;
               if (g_r.cnt == 5'd1) begin
                  g_nxt.st = SSD_G_STORE;
               end
            end
         end
         SSD_G_STORE: begin
            g_nxt.idx = (g_r.idx >= last) ? 5'd0 : g_r.idx + 5'd1;
            g_nxt.st  = SSD_G_IDLE;
         end
         default: g_nxt.st = SSD_G_IDLE;
      endcase
      g_nxt.rdata = 8'h00;
      if (rd && sel < 5'(MAX_SENSORS)) begin
         case (addr[7:6])
            2'd0:    g_nxt.rdata = req_mem[sel];
            2'd1:    g_nxt.rdata = rsp_mem[sel];
            2'd2:    g_nxt.rdata = warn_mem[sel];
            default: g_nxt.rdata = err_mem[sel];
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         g_r    <= '0;
         g_r.st <= SSD_G_IDLE;
      end else begin
         g_r <= g_nxt;
      end
   end

   // Byte stores: a reply that arrives alongside software writes wins nothing; sets differ.
   always_ff @(posedge clock) begin
      if (wr && addr[7:6] == 2'd0 && sel < 5'(MAX_SENSORS)) begin
         req_mem[sel] <= wdata;
      end
      if (g_r.st == SSD_G_STORE) begin
         rsp_mem[g_r.idx]  <= g_r.rx[23:16];
         warn_mem[g_r.idx] <= g_r.rx[15:8];
         err_mem[g_r.idx]  <= g_r.rx[7:0];
      end
   end

   assign rdata                        = g_r.rdata;
   assign serial_diagnostic.req_valid  = g_r.v;
   assign serial_diagnostic.req_bit    = g_r.b;
   assign serial_diagnostic.sensor_idx = g_r.idx;

endmodule : ssd_gateway

// ### tb/ssd_link_chk.sv
// Checker for one sensor joined to the chain gateway: link framing and pin states.
// Assumes the bench instantiates it beside the link and wires every signal by name.
`timescale 1ns/1ps
module ssd_link_chk (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // Link signals
   input wire logic       req_valid,
   input wire logic       req_bit,
   input wire logic       rsp_valid,
   input wire logic       rsp_bit,
   input wire logic [4:0] sensor_idx,
   // Sensor pins
   input wire logic       link_error,
   input wire logic       safety_output_one,
   input wire logic       safety_output_two,
   input wire logic       diag_out,
   input wire logic       led_green,
   input wire logic       led_yellow,
   input wire logic       led_red
);
   // ---------------------------------------------------------------
   // Reply length counter
   // ---------------------------------------------------------------
   // A repetition of 24 would be too costly to unroll, so the run is counted.
   logic [4:0] run_r;
   logic [4:0] run_nxt;
   always_comb run_nxt = rsp_valid ? run_r + 5'h01 : 5'h00;
   always_ff @(posedge clock) run_r <= reset_n ? run_nxt : 5'h00;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_req_eight_bits: assert property ($rose(req_valid) |-> req_valid [*8] ##1 !req_valid)
      else $error("request frame is not eight bits long");
   a_reply_follows: assert property ($fell(req_valid) |-> ##[1:3] $rose(rsp_valid))
      else $error("reply did not follow the request");
   a_reply_length: assert property ($fell(rsp_valid) |-> run_r == 5'h18)
      else $error("reply is not twenty-four bits long");
   a_link_one_way: assert property (!(req_valid && rsp_valid))
      else $error("request and reply overlap");
   a_chain_limit: assert property (sensor_idx < 5'h1F)
      else $error("polled index beyond the chain limit");
   a_outputs_paired: assert property (safety_output_one == safety_output_two)
      else $error("safety outputs disagree");
   a_green_alone: assert property (led_green |-> !led_yellow && !led_red && !diag_out
                                   && !safety_output_one)
      else $error("green shown with another indication");
   a_fault_diag_low: assert property (led_red |-> !diag_out && !led_green)
      else $error("diagnostic output high during a fault");
   a_link_hold: assert property (link_error && $past(link_error) |->
                                 $stable(safety_output_one))
      else $error("safety outputs moved during a link error");

   c_reply: cover property ($fell(rsp_valid));
   c_fault: cover property (led_red && !safety_output_one);
   c_warning: cover property (led_red && safety_output_one);
   c_link_hold: cover property (link_error && safety_output_one);
endmodule : ssd_link_chk

// ### tb/safety_sensor_diagnostics_test.sv
// Bench joining one sensor to the chain gateway; checks pins and stored status bytes.
// Assumes the gateway polls a chain of one sensor at index zero.
`timescale 1ns/1ps
module safety_sensor_diagnostics_test;
   import ssd_pkg::*;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic       actuator_in = 1'b0;
   logic       hyst_in = 1'b0;
   logic       in_one = 1'b1;
   logic       in_two = 1'b1;
   logic [7:0] fault_in = 8'h00;
   logic       link_error = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       so1, so2, diag, g, y, r;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;
   int         seed = 78;
   ssd_mode_e  m;
   ssd_link_if link ();

   ssd_sensor ssd_sensor_inst (.clock(clock), .reset_n(reset_n), .actuator_in(actuator_in),
      .hyst_in(hyst_in), .safety_input_one(in_one), .safety_input_two(in_two),
      .fault_in(fault_in), .link_error(link_error), .my_index(5'h00),
      .serial_diagnostic(link), .safety_output_one(so1), .safety_output_two(so2),
      .diag_out(diag), .led_green(g), .led_yellow(y), .led_red(r));
   ssd_gateway ssd_gateway_inst (.clock(clock), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chain_len(5'h01),
      .serial_diagnostic(link));
   ssd_link_chk ssd_link_chk_inst (.clock(clock), .reset_n(reset_n),
      .req_valid(link.req_valid), .req_bit(link.req_bit), .rsp_valid(link.rsp_valid),
      .rsp_bit(link.rsp_bit), .sensor_idx(link.sensor_idx), .link_error(link_error),
      .safety_output_one(so1), .safety_output_two(so2), .diag_out(diag),
      .led_green(g), .led_yellow(y), .led_red(r));

   always #10 clock = ~clock;

   // ---------------------------------------------------------------
   // Closing report and hang guard
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Bus cycles, stimulus and comparisons
   // ---------------------------------------------------------------
   task automatic settle;
      repeat (120) @(posedge clock);
   endtask : settle

   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_byte

   task automatic check_byte(input string s, input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      n_tests++;
      if (rdata !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", s, e, rdata);
      end
   endtask : check_byte

   task automatic check_pins(input logic [5:0] e, input logic [5:0] k);
      logic [5:0] v;
      #1;
      v = {so1, so2, diag, g, y, r};
      n_tests++;
      if ((v & k) !== (e & k)) begin
         num_errors++;
         $display("unexpected pins expected %b seen %b", e & k, v & k);
      end
   endtask : check_pins

   task automatic pins_set(input logic a, input logic h, input logic [7:0] f);
      @(posedge clock);
      actuator_in <= a;
      hyst_in     <= h;
      fault_in    <= f;
      settle();
   endtask : pins_set

   // Flashing indications are masked: their phase is not defined at this scale.
   function automatic logic [19:0] expect_of(ssd_mode_e md);
      case (md)
         SSD_IDLE: expect_of = {8'h10, 6'b000100, 6'b111111};
         SSD_ON:   expect_of = {8'h13, 6'b111010, 6'b111111};
         SSD_HYST: expect_of = {8'h33, 6'b110000, 6'b110101};
         SSD_WARN: expect_of = {8'h53, 6'b110000, 6'b111110};
         default:  expect_of = {8'hD2, 6'b000000, 6'b111110};
      endcase
   endfunction : expect_of

   task automatic drive(input ssd_mode_e md);
      pins_set(md != SSD_IDLE, md == SSD_HYST,
               md == SSD_WARN ? 8'h08 : (md == SSD_ERROR ? 8'h10 : 8'h00));
   endtask : drive

   task automatic verify(input ssd_mode_e md);
      logic [19:0] x;
      x = expect_of(md);
      check_pins(x[11:6], x[5:0]);
      check_byte("response", 8'h40, x[19:12]);
      if (md == SSD_WARN) check_byte("warning cause", 8'h80, 8'h08);
      if (md == SSD_ERROR) check_byte("error cause", 8'hC0, 8'h10);
   endtask : verify

   initial begin
      repeat (18) @(posedge clock);
      wr_byte(8'h00, 8'h00);
      reset_n <= 1'b1;
      settle();
      verify(SSD_IDLE);
      $display("test idle done");
      for (int i = 0; i < 12; i++) begin
         m = ssd_mode_e'(3'({$random(seed)} % 4));
         drive(m);
         verify(m);
      end
      $display("test random done");
      drive(SSD_ERROR);
      verify(SSD_ERROR);
      pins_set(1'b1, 1'b0, 8'h00);
      verify(SSD_ERROR);
      wr_byte(8'h00, 8'h80);
      settle();
      wr_byte(8'h00, 8'h00);
      settle();
      verify(SSD_ON);
      $display("test error reset done");
      pins_set(1'b1, 1'b0, 8'h11);
      pins_set(1'b0, 1'b0, 8'h00);
      check_byte("output fault", 8'hC0, 8'h01);
      pins_set(1'b1, 1'b0, 8'h00);
      wr_byte(8'h00, 8'h80);
      settle();
      wr_byte(8'h00, 8'h00);
      settle();
      verify(SSD_ON);
      $display("test output fault done");
      drive(SSD_ERROR);
      pins_set(1'b0, 1'b0, 8'h00);
      verify(SSD_IDLE);
      drive(SSD_ON);
      verify(SSD_ON);
      $display("test guard open done");
      @(posedge clock);
      link_error <= 1'b1;
      pins_set(1'b0, 1'b0, 8'h00);
      check_pins(6'b110000, 6'b110000);
      @(posedge clock);
      link_error <= 1'b0;
      settle();
      verify(SSD_IDLE);
      $display("test link error done");
      check_byte("beyond chain", 8'h5F, 8'h00);
      @(posedge clock);
      in_one <= 1'b0;
      settle();
      check_byte("inputs dead", 8'h40, 8'h00);
      $display("test refusal done");
      conclude();
   end
endmodule : safety_sensor_diagnostics_test
